// >>> include/atd_pkg.sv
// Constants shared by the accumulator transfer decode block
package atd_pkg;

   // ==========================================================
   // Instruction word layout
   // ==========================================================
   localparam int ATD_CODE_W = 10;
   localparam int ATD_NIB_W = 4;
   localparam int ATD_PAGE_W = 2;
   localparam int ATD_ADDR_W = ATD_PAGE_W + 2 * ATD_NIB_W;
   localparam int ATD_IMM_LSB = 0;

   // ==========================================================
   // Opcodes and match masks
   // ==========================================================
   localparam logic [ATD_CODE_W-1:0] ATD_OP_WAKEUP_CTRL2 = 10'h215;
   localparam logic [ATD_CODE_W-1:0] ATD_OP_CLOCK_CTRL = 10'h216;
   localparam logic [ATD_CODE_W-1:0] ATD_OP_PULLUP_CTRL0 = 10'h22D;
   localparam logic [ATD_CODE_W-1:0] ATD_OP_STORE_MEM = 10'h2B0;
   localparam logic [ATD_CODE_W-1:0] ATD_MASK_FULL = 10'h3FF;
   localparam logic [ATD_CODE_W-1:0] ATD_MASK_STORE = 10'h3F0;

   // ==========================================================
   // Values after reset
   // ==========================================================
   localparam logic [ATD_NIB_W-1:0] ATD_RST_NIB = 4'h0;
   localparam logic [ATD_ADDR_W-1:0] ATD_RST_ADDR = 10'h000;

endpackage

// >>> src/atd_opcode_match.sv
// Masked comparison of an instruction word against one opcode pattern
`timescale 1ns/100ps
module atd_opcode_match
   import atd_pkg::*;
#(
   parameter logic [ATD_CODE_W-1:0] PATTERN = 10'h000,
   parameter logic [ATD_CODE_W-1:0] MASK = 10'h3FF
) (
   input wire logic [ATD_CODE_W-1:0] code,
   input wire logic valid,
   output logic hit
);

   // ==========================================================
   // Compare only the bits selected by the mask
   // ==========================================================
   assign hit = valid && ((code & MASK) == (PATTERN & MASK));

endmodule

// >>> src/atd_top.sv
// Decode and execution of four accumulator transfer instructions
`timescale 1ns/100ps
// Summary of operation
// - Opcode 1000010101 copies accumulator into wakeup_ctrl2, one cycle, no carry/skip.
// - Opcode 101011jjjj stores accumulator to memory and XORs pointer X with immediate j; carry and skip untouched.
// - Opcode 1000010110 copies accumulator into clock_ctrl_reg in one cycle.
// - Opcode 1000101101 copies accumulator into pullup_ctrl0 in one cycle.
module atd_top
   import atd_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic clk_en,
   input wire logic instr_valid,
   input wire logic [ATD_CODE_W-1:0] instr_code,
   input wire logic [ATD_NIB_W-1:0] acc,
   input wire logic [ATD_PAGE_W-1:0] ptr_z,
   input wire logic [ATD_NIB_W-1:0] ptr_y,
   input wire logic x_load,
   input wire logic [ATD_NIB_W-1:0] x_load_data,
   output logic [ATD_NIB_W-1:0] x_ptr,
   output logic [ATD_NIB_W-1:0] wakeup_ctrl2,
   output logic [ATD_NIB_W-1:0] clock_ctrl_reg,
   output logic [ATD_NIB_W-1:0] pullup_ctrl0,
   output logic ram_we,
   output logic [ATD_ADDR_W-1:0] ram_pointer,
   output logic [ATD_NIB_W-1:0] ram_wdata,
   output logic op_done,
   output logic skip_next,
   output logic carry_we
);

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (rst);

   // ==========================================================
   // State
   // ==========================================================
   typedef struct packed {
      logic [ATD_NIB_W-1:0] x_ptr;
      logic [ATD_NIB_W-1:0] wakeup_ctrl2;
      logic [ATD_NIB_W-1:0] clock_ctrl_reg;
      logic [ATD_NIB_W-1:0] pullup_ctrl0;
      logic ram_we;
      logic [ATD_ADDR_W-1:0] ram_pointer;
      logic [ATD_NIB_W-1:0] ram_wdata;
      logic op_done;
   } atd_state_t;

   atd_state_t st;
   atd_state_t next_st;

   logic hit_wakeup;
   logic hit_clock;
   logic hit_pullup;
   logic hit_store;
   logic [ATD_NIB_W-1:0] imm;

   // ==========================================================
   // Opcode decoders
   // ==========================================================
   atd_opcode_match #(
      .PATTERN(ATD_OP_WAKEUP_CTRL2),
      .MASK(ATD_MASK_FULL)
   ) u_match_wakeup (
      .code(instr_code),
      .valid(instr_valid),
      .hit(hit_wakeup)
   );

   atd_opcode_match #(
      .PATTERN(ATD_OP_CLOCK_CTRL),
      .MASK(ATD_MASK_FULL)
   ) u_match_clock (
      .code(instr_code),
      .valid(instr_valid),
      .hit(hit_clock)
   );

   atd_opcode_match #(
      .PATTERN(ATD_OP_PULLUP_CTRL0),
      .MASK(ATD_MASK_FULL)
   ) u_match_pullup (
      .code(instr_code),
      .valid(instr_valid),
      .hit(hit_pullup)
   );

   atd_opcode_match #(
      .PATTERN(ATD_OP_STORE_MEM),
      .MASK(ATD_MASK_STORE)
   ) u_match_store (
      .code(instr_code),
      .valid(instr_valid),
      .hit(hit_store)
   );

   assign imm = instr_code[ATD_IMM_LSB +: ATD_NIB_W];

   // ==========================================================
   // Next state
   // ==========================================================
   always_comb begin
      next_st = st;
      next_st.ram_we = 1'b0;
      next_st.op_done = 1'b0;
      if (x_load) begin
         next_st.x_ptr = x_load_data;
      end
      if (hit_wakeup) begin
         next_st.wakeup_ctrl2 = acc;
         next_st.op_done = 1'b1;
      end
      if (hit_clock) begin
         next_st.clock_ctrl_reg = acc;
         next_st.op_done = 1'b1;
      end
      if (hit_pullup) begin
         next_st.pullup_ctrl0 = acc;
         next_st.op_done = 1'b1;
      end
      if (hit_store) begin
         // Address taken from the pointer before the toggle lands
         next_st.ram_pointer = {ptr_z, st.x_ptr, ptr_y};
         next_st.ram_wdata = acc;
         next_st.ram_we = 1'b1;
         next_st.x_ptr = st.x_ptr ^ imm;
         next_st.op_done = 1'b1;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         st.x_ptr <= ATD_RST_NIB;
         st.wakeup_ctrl2 <= ATD_RST_NIB;
         st.clock_ctrl_reg <= ATD_RST_NIB;
         st.pullup_ctrl0 <= ATD_RST_NIB;
         st.ram_we <= 1'b0;
         st.ram_pointer <= ATD_RST_ADDR;
         st.ram_wdata <= ATD_RST_NIB;
         st.op_done <= 1'b0;
      end else if (clk_en) begin
         st <= next_st;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign x_ptr = st.x_ptr;
   assign wakeup_ctrl2 = st.wakeup_ctrl2;
   assign clock_ctrl_reg = st.clock_ctrl_reg;
   assign pullup_ctrl0 = st.pullup_ctrl0;
   assign ram_we = st.ram_we;
   assign ram_pointer = st.ram_pointer;
   assign ram_wdata = st.ram_wdata;
   assign op_done = st.op_done;
   // None of these instructions skips or touches carry
   assign skip_next = 1'b0;
   assign carry_we = 1'b0;

   // ==========================================================
   // Checks
   // ==========================================================
   sequence s_store_taken;
      clk_en && hit_store;
   endsequence

   sequence s_ctrl_taken;
      clk_en && (hit_wakeup || hit_clock || hit_pullup);
   endsequence

   a_wakeup_load: assert property (
      clk_en && instr_valid && instr_code == ATD_OP_WAKEUP_CTRL2
      |=> wakeup_ctrl2 == $past(acc) && op_done && !skip_next && !carry_we)
      else $error("wakeup control not loaded from accumulator");

   a_store_write: assert property (
      s_store_taken |=> ram_we && ram_wdata == $past(acc))
      else $error("memory store did not write accumulator");

   a_store_quiet: assert property (
      clk_en && !hit_store |=> !ram_we)
      else $error("memory write without store instruction");

   a_pointer_toggle: assert property (
      s_store_taken |=> x_ptr == ($past(x_ptr) ^ $past(instr_code[3:0])))
      else $error("pointer not toggled by immediate");

   a_clock_load: assert property (
      clk_en && instr_valid && instr_code == ATD_OP_CLOCK_CTRL
      |=> clock_ctrl_reg == $past(acc) && op_done)
      else $error("clock control not loaded from accumulator");

   a_pullup_load: assert property (
      clk_en && instr_valid && instr_code == ATD_OP_PULLUP_CTRL0
      |=> pullup_ctrl0 == $past(acc) && op_done)
      else $error("pull-up control not loaded from accumulator");

   a_ctrl_single: assert property (
      s_ctrl_taken ##1 clk_en && !instr_valid |=> !op_done)
      else $error("control transfer took more than one cycle");

   a_addr_before: assert property (
      s_store_taken
      |=> ram_pointer == {$past(ptr_z), $past(x_ptr), $past(ptr_y)})
      else $error("store address not formed from old pointer");

   a_ctrl_hold: assert property (
      !clk_en |=> $stable(wakeup_ctrl2) && $stable(clock_ctrl_reg) && $stable(pullup_ctrl0)
         && $stable(x_ptr) && $stable(ram_we) && $stable(ram_pointer) && $stable(op_done))
      else $error("state changed while clock enable low");

endmodule

// >>> test/atd_testbench.sv
// Self-checking random testbench for the accumulator transfer decode block
`timescale 1ns/100ps
module testbench
   import atd_pkg::*;
;
   // ==========================================================
   // Stimulus, model state and scoreboard
   // ==========================================================
   typedef struct packed {
      logic [3:0] w, c, p, x;
      logic we;
      logic [9:0] ptr;
      logic [3:0] wd;
   } atd_snap_t;
   logic sys_clk = 1'b0, rst = 1'b1, clk_en = 1'b0, instr_valid = 1'b0, x_load = 1'b0;
   logic [9:0] instr_code = 10'h000;
   logic [3:0] acc = 4'h0, ptr_y = 4'h0, x_load_data = 4'h0;
   logic [1:0] ptr_z = 2'h0;
   logic [3:0] x_ptr, wakeup_ctrl2, clock_ctrl_reg, pullup_ctrl0, ram_wdata;
   logic [9:0] ram_pointer;
   logic ram_we, op_done, skip_next, carry_we;
   atd_snap_t m = '0, e, got;
   atd_snap_t q[$];
   bit rst_q = 1'b1, en_q = 1'b0;
   int miscompares = 0, total_checks = 0;
   atd_top i_atd_top (.sys_clk(sys_clk), .rst(rst), .clk_en(clk_en), .instr_valid(instr_valid),
      .instr_code(instr_code), .acc(acc), .ptr_z(ptr_z), .ptr_y(ptr_y), .x_load(x_load),
      .x_load_data(x_load_data), .x_ptr(x_ptr), .wakeup_ctrl2(wakeup_ctrl2),
      .clock_ctrl_reg(clock_ctrl_reg), .pullup_ctrl0(pullup_ctrl0), .ram_we(ram_we),
      .ram_pointer(ram_pointer), .ram_wdata(ram_wdata), .op_done(op_done),
      .skip_next(skip_next), .carry_we(carry_we));
   initial begin
      forever #20 sys_clk = ~sys_clk;
   end
   task chk(input logic [9:0] g, input logic [9:0] x, input string what);
      total_checks++;
      if (g !== x) begin
         miscompares++;
         $display("ERROR %0t: %s got %h exp %h", $time, what, g, x);
      end
   endtask
   task end_sim;
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ==========================================================
   // Reference model at the sampling edge, then new random inputs
   // ==========================================================
   task step(input bit do_rst);
      bit hit;
      @(posedge sys_clk);
      rst_q = rst;
      en_q = clk_en;
      hit = 1'b0;
      m.we = 1'b0;
      if (rst) begin
         m = '0;
         q.delete();
      end else if (clk_en) begin
         if (instr_valid && instr_code == ATD_OP_WAKEUP_CTRL2) {m.w, hit} = {acc, 1'b1};
         if (instr_valid && instr_code == ATD_OP_CLOCK_CTRL) {m.c, hit} = {acc, 1'b1};
         if (instr_valid && instr_code == ATD_OP_PULLUP_CTRL0) {m.p, hit} = {acc, 1'b1};
         if (instr_valid && (instr_code & ATD_MASK_STORE) == ATD_OP_STORE_MEM) begin
            m.ptr = {ptr_z, m.x, ptr_y};
            m.wd = acc;
            m.we = 1'b1;
            m.x = m.x ^ instr_code[3:0];
            hit = 1'b1;
         end else if (x_load) begin
            m.x = x_load_data;
         end
         if (hit) q.push_back(m);
      end
      rst <= do_rst;
      clk_en <= ($urandom % 8) != 0;
      instr_valid <= !do_rst && ($urandom % 8) != 0;
      case ($urandom % 6)
         0: instr_code <= ATD_OP_WAKEUP_CTRL2;
         1: instr_code <= ATD_OP_CLOCK_CTRL;
         2: instr_code <= ATD_OP_PULLUP_CTRL0;
         3: instr_code <= ATD_OP_STORE_MEM | 10'($urandom % 16);
         4: instr_code <= 10'($urandom);
         default: instr_code <= ATD_OP_WAKEUP_CTRL2 ^ (10'h001 << ($urandom % 10));
      endcase
      acc <= 4'($urandom);
      ptr_z <= 2'($urandom);
      ptr_y <= 4'($urandom);
      x_load <= ($urandom % 4) == 0;
      x_load_data <= 4'($urandom);
   endtask
   // ==========================================================
   // Output watcher: one note taken per executed instruction
   // ==========================================================
   always @(negedge sys_clk) begin
      got = {wakeup_ctrl2, clock_ctrl_reg, pullup_ctrl0, x_ptr, ram_we, ram_pointer, ram_wdata};
      chk(10'(skip_next), 10'h000, "skip");
      chk(10'(carry_we), 10'h000, "carry");
      if (rst_q) begin
         chk(10'(got != '0), 10'h000, "reset state");
      end else if (en_q) begin
         if (op_done === 1'b1 && q.size() > 0) begin
            e = q.pop_front();
            chk(10'(got.w), 10'(e.w), "wakeup_ctrl2");
            chk(10'(got.c), 10'(e.c), "clock_ctrl_reg");
            chk(10'(got.p), 10'(e.p), "pullup_ctrl0");
            chk(10'(got.x), 10'(e.x), "x_ptr");
            chk(10'(got.we), 10'(e.we), "ram_we");
            chk(got.ptr, e.ptr, "ram_pointer");
            chk(10'(got.wd), 10'(e.wd), "ram_wdata");
         end else begin
            chk(10'(op_done), 10'(q.size() > 0), "op_done");
            chk(10'(ram_we), 10'h000, "idle ram_we");
            q.delete();
         end
      end
   end
   initial begin
      #(40 * 6000);
      miscompares++;
      $display("ERROR %0t: watchdog expired", $time);
      end_sim();
   end
   initial begin
      void'($urandom(23336));
      repeat (20) step(1'b1);
      repeat (2000) step(1'b0);
      repeat (2) step(1'b1);
      repeat (2000) step(1'b0);
      end_sim();
   end
endmodule
